// ### core/cjx_consts.svh
// Offsets, field positions, codes and timing figures of the jump block
`ifndef CJX_CONSTS_SVH
`define CJX_CONSTS_SVH
`define CJX_CLK_NS 10
`define CJX_T56_US 56
`define CJX_T52_US 52
`define CJX_T41_US 41
`define CJX_T40_US 40
`define CJX_T36_US 36
`define CJX_T29_US 29
`define CJX_T20_US 20
`define CJX_OP_EXF 6'h38
`define CJX_OP_SENSE 6'h3C
`define CJX_OP_SWJ 6'h3D
`define CJX_OP_SWS 6'h3E
`define CJX_REG_CTRL 4'h0
`define CJX_REG_STAT 4'h4
`define CJX_REG_EFC 4'h8
`define CJX_REG_PADR 4'hC
`define CJX_CTRL_TRACE 0
`define CJX_CTRL_RUN 1
`define CJX_STAT_SEND 0
`define CJX_STAT_HOLD 1
`define CJX_STAT_HUNG 2
`define CJX_STAT_BUSY 3
`define CJX_STAT_HALT 4
`define CJX_STAT_TRACE 5
`define CJX_TRACE_SLOT 15'h0000
`define CJX_MON_ENTRY 15'h0001
`endif

// ### core/cjx_pkg.sv
// Types shared by the jump and external function block
package cjx_pkg;
   typedef enum logic [1:0] {
      CJX_IDLE = 2'b00,
      CJX_EXEC = 2'b01,
      CJX_EXF = 2'b10,
      CJX_HANG = 2'b11
   } cjx_state_t;
   typedef enum logic [1:0] {
      CJX_NOJ = 2'b00,
      CJX_NORM = 2'b01,
      CJX_RET = 2'b10,
      CJX_TRC = 2'b11
   } cjx_jump_t;
   typedef struct packed {
      logic [5:0] opcode;
      logic [2:0] m;
      logic [2:0] b;
      logic [14:0] y;
   } cjx_instr_t;
   typedef struct packed {
      logic [14:0] next_p;
      logic st_en;
      logic [14:0] st_addr;
      logic [14:0] st_data;
   } cjx_result_t;
endpackage

// ### core/cjx_core.sv
// Conditional jump, switch stop and external function execution unit
`timescale 1ns/100ps
`include "cjx_consts.svh"
module cjx_core #(
   parameter int T56_CYC = `CJX_T56_US * 1000 / `CJX_CLK_NS,
   parameter int T52_CYC = `CJX_T52_US * 1000 / `CJX_CLK_NS,
   parameter int T41_CYC = `CJX_T41_US * 1000 / `CJX_CLK_NS,
   parameter int T40_CYC = `CJX_T40_US * 1000 / `CJX_CLK_NS,
   parameter int T36_CYC = `CJX_T36_US * 1000 / `CJX_CLK_NS,
   parameter int T29_CYC = `CJX_T29_US * 1000 / `CJX_CLK_NS,
   parameter int T20_CYC = `CJX_T20_US * 1000 / `CJX_CLK_NS
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic issue_valid,
   input wire cjx_pkg::cjx_instr_t issue_instr,
   input wire logic [14:0] issue_p,
   input wire logic [14:0] index_val,
   input wire logic rpt_active,
   output logic issue_ready,
   input wire logic [2:0] jump_sw,
   input wire logic [2:0] stop_sw,
   input wire logic ext_sense,
   input wire logic in_full,
   input wire logic out_empty,
   input wire logic trace_set,
   output cjx_pkg::cjx_result_t res,
   output logic done,
   output logic rpt_end,
   output logic halted,
   output cjx_pkg::cjx_instr_t u_instr,
   output logic [14:0] ef_code,
   output logic ef_send,
   input wire logic ef_resume,
   input wire logic ef_hold,
   input wire logic io_done,
   output logic ef_hung
);

   // Pick one of four conditions by the low modifier bits
   function automatic logic cjx_pick(
      input logic [1:0] sel,
      input logic c0,
      input logic c1,
      input logic c2,
      input logic c3
   );
      logic r;
      case (sel)
         2'h0: r = c0;
         2'h1: r = c1;
         2'h2: r = c2;
         default: r = c3;
      endcase
      return r;
   endfunction

   // Operand address, index-modified when a designator is given
   function automatic logic [14:0] cjx_operand(
      input logic [2:0] b,
      input logic [14:0] y,
      input logic [14:0] idx
   );
      logic [14:0] a;
      a = (b != 3'h0) ? 15'(y + idx) : y;
      return a;
   endfunction

   function automatic logic [12:0] cjx_cnt(input int cyc);
      logic [12:0] c;
      c = (cyc > 1) ? 13'(cyc - 1) : 13'h0000;
      return c;
   endfunction

   cjx_pkg::cjx_state_t state_r;
   cjx_pkg::cjx_jump_t kind_r;
   cjx_pkg::cjx_jump_t kind_nxt;
   logic [12:0] cnt_r;
   logic [12:0] cnt_nxt;
   logic [14:0] y_r;
   logic [14:0] ret_r;
   logic stop_r;
   logic stop_nxt;
   logic take;
   logic rpt_stop;
   logic [14:0] opnd;
   logic accept;
   logic is_jmp;
   logic is_exf;
   logic lock;
   logic trace_r;
   logic hold_r;
   logic ack_r;
   logic bus_req;
   logic wr_ctrl;
   logic [31:0] rd_nxt;
   logic [5:0] st_bits;

   assign opnd = cjx_operand(issue_instr.b, issue_instr.y, index_val);
   assign accept = issue_valid && issue_ready;
   assign is_exf = issue_instr.opcode == `CJX_OP_EXF;
   assign is_jmp = issue_instr.opcode == `CJX_OP_SENSE
      || issue_instr.opcode == `CJX_OP_SWJ
      || issue_instr.opcode == `CJX_OP_SWS;
   assign lock = ef_send || hold_r || ef_hung;
   assign bus_req = avs_read || avs_write;
   assign wr_ctrl = avs_write && ack_r && avs_address == `CJX_REG_CTRL;

   // Jump decision, taken on the switch and status levels at issue
   always_comb
   begin
      take = 1'b0;
      stop_nxt = 1'b0;
      rpt_stop = 1'b0;
      cnt_nxt = cjx_cnt(T40_CYC);
      case (issue_instr.opcode)
         `CJX_OP_SENSE:
         begin
            take = cjx_pick(issue_instr.m[1:0], ext_sense, in_full,
               out_empty, !lock);
            rpt_stop = take;
            if (take && (issue_instr.m[2] || trace_r))
               cnt_nxt = cjx_cnt(T56_CYC);
         end
         `CJX_OP_SWJ:
         begin
            take = cjx_pick(issue_instr.m[1:0], 1'b1, jump_sw[0],
               jump_sw[1], jump_sw[2]);
            rpt_stop = take;
            if (!take && rpt_active)
               cnt_nxt = cjx_cnt(T20_CYC);
            else if (take && (issue_instr.m[2] || trace_r))
               cnt_nxt = cjx_cnt(T56_CYC);
         end
         `CJX_OP_SWS:
         begin
            take = 1'b1;
            stop_nxt = cjx_pick(issue_instr.m[1:0], 1'b1, stop_sw[0],
               stop_sw[1], stop_sw[2]);
            rpt_stop = 1'b1;
            if (issue_instr.m[2])
               cnt_nxt = (stop_nxt && issue_instr.m[1:0] != 2'h0)
                  ? cjx_cnt(T41_CYC) : cjx_cnt(T52_CYC);
            else
               cnt_nxt = (stop_nxt && issue_instr.m[1:0] != 2'h0)
                  ? cjx_cnt(T29_CYC) : cjx_cnt(T36_CYC);
         end
         default:
         begin
            take = 1'b0;
         end
      endcase
      if (!take)
         kind_nxt = cjx_pkg::CJX_NOJ;
      else if (trace_r)
         kind_nxt = cjx_pkg::CJX_TRC;
      else if (issue_instr.m[2])
         kind_nxt = cjx_pkg::CJX_RET;
      else
         kind_nxt = cjx_pkg::CJX_NORM;
   end

   // Instruction sequencing, jump completion and function handshake
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r <= cjx_pkg::CJX_IDLE;
         kind_r <= cjx_pkg::CJX_NOJ;
         cnt_r <= 13'h0000;
         y_r <= 15'h0000;
         ret_r <= 15'h0000;
         stop_r <= 1'b0;
         issue_ready <= 1'b1;
         done <= 1'b0;
         rpt_end <= 1'b0;
         halted <= 1'b0;
         res <= '0;
         u_instr <= '0;
         ef_code <= 15'h0000;
         ef_send <= 1'b0;
         ef_hung <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         rpt_end <= 1'b0;
         case (state_r)
            cjx_pkg::CJX_IDLE:
            begin
               if (halted && wr_ctrl && avs_writedata[`CJX_CTRL_RUN])
               begin
                  halted <= 1'b0;
                  issue_ready <= 1'b1;
               end
               else if (accept)
               begin
                  issue_ready <= 1'b0;
                  u_instr <= issue_instr;
                  y_r <= opnd;
                  ret_r <= 15'(issue_p + 15'h0001);
                  if (is_exf && hold_r)
                  begin
                     state_r <= cjx_pkg::CJX_HANG;
                     ef_hung <= 1'b1;
                  end
                  else if (is_exf)
                  begin
                     ef_code <= opnd;
                     ef_send <= 1'b1;
                     state_r <= cjx_pkg::CJX_EXF;
                  end
                  else if (is_jmp)
                  begin
                     kind_r <= kind_nxt;
                     stop_r <= stop_nxt;
                     cnt_r <= cnt_nxt;
                     rpt_end <= rpt_active && rpt_stop;
                     state_r <= cjx_pkg::CJX_EXEC;
                  end
                  else
                  begin
                     issue_ready <= 1'b1;
                  end
               end
            end
            cjx_pkg::CJX_EXEC:
            begin
               if (cnt_r != 13'h0000)
                  cnt_r <= cnt_r - 13'h0001;
               else
               begin
                  done <= 1'b1;
                  state_r <= cjx_pkg::CJX_IDLE;
                  res.st_en <= 1'b0;
                  res.st_addr <= y_r;
                  res.st_data <= ret_r;
                  case (kind_r)
                     cjx_pkg::CJX_NORM:
                        res.next_p <= y_r;
                     cjx_pkg::CJX_RET:
                     begin
                        res.st_en <= 1'b1;
                        res.next_p <= 15'(y_r + 15'h0001);
                     end
                     cjx_pkg::CJX_TRC:
                     begin
                        res.st_en <= 1'b1;
                        res.st_addr <= `CJX_TRACE_SLOT;
                        res.next_p <= `CJX_MON_ENTRY;
                     end
                     default:
                        res.next_p <= ret_r;
                  endcase
                  halted <= stop_r;
                  issue_ready <= !stop_r;
               end
            end
            cjx_pkg::CJX_EXF:
            begin
               if (ef_resume)
               begin
                  ef_send <= 1'b0;
                  done <= 1'b1;
                  res.st_en <= 1'b0;
                  res.next_p <= ret_r;
                  issue_ready <= 1'b1;
                  state_r <= cjx_pkg::CJX_IDLE;
               end
            end
            cjx_pkg::CJX_HANG:
            begin
               state_r <= cjx_pkg::CJX_HANG;
            end
            default:
            begin
               state_r <= cjx_pkg::CJX_IDLE;
            end
         endcase
      end
   end

   // Lock held past resume by functions that wait for an I/O instruction
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         hold_r <= 1'b0;
      else if (state_r == cjx_pkg::CJX_EXF && ef_resume && ef_hold)
         hold_r <= 1'b1;
      else if (io_done)
         hold_r <= 1'b0;
   end

   // Trace flag: set by console or software, cleared by the traced jump
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         trace_r <= 1'b0;
      else if (trace_set || (wr_ctrl && avs_writedata[`CJX_CTRL_TRACE]))
         trace_r <= 1'b1;
      else if (accept && is_jmp && kind_nxt == cjx_pkg::CJX_TRC)
         trace_r <= 1'b0;
   end

   // Register read multiplexer
   always_comb
   begin
      st_bits = 6'h00;
      st_bits[`CJX_STAT_SEND] = ef_send;
      st_bits[`CJX_STAT_HOLD] = hold_r;
      st_bits[`CJX_STAT_HUNG] = ef_hung;
      st_bits[`CJX_STAT_BUSY] = state_r != cjx_pkg::CJX_IDLE;
      st_bits[`CJX_STAT_HALT] = halted;
      st_bits[`CJX_STAT_TRACE] = trace_r;
      case (avs_address)
         `CJX_REG_CTRL:
            rd_nxt = {30'h00000000, halted, trace_r};
         `CJX_REG_STAT:
            rd_nxt = {26'h0000000, st_bits};
         `CJX_REG_EFC:
            rd_nxt = {17'h00000, ef_code};
         `CJX_REG_PADR:
            rd_nxt = {17'h00000, res.next_p};
         default:
            rd_nxt = 32'h00000000;
      endcase
   end

   // Avalon slave: one wait cycle, answer on the second edge
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ack_r <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end
      else
      begin
         ack_r <= bus_req && !ack_r;
         avs_waitrequest <= !(bus_req && !ack_r);
         if (avs_read && !ack_r)
            avs_readdata <= rd_nxt;
      end
   end

endmodule

// ### dv/cjx_core_sva.sv
// Checker bound to the jump and external function block
`timescale 1ns/100ps
`include "cjx_consts.svh"
module cjx_core_sva #(
   parameter int T56_CYC = 5600
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic avs_write,
   input wire logic issue_valid,
   input wire cjx_pkg::cjx_instr_t issue_instr,
   input wire logic [14:0] index_val,
   input wire logic rpt_active,
   input wire logic issue_ready,
   input wire logic [2:0] jump_sw,
   input wire logic in_full,
   input wire cjx_pkg::cjx_result_t res,
   input wire logic done,
   input wire logic rpt_end,
   input wire logic halted,
   input wire cjx_pkg::cjx_instr_t u_instr,
   input wire logic [14:0] ef_code,
   input wire logic ef_send,
   input wire logic ef_resume,
   input wire logic ef_hung
);
   localparam int TMAX = T56_CYC + 2;
   logic take;
   logic [5:0] opc;
   logic [2:0] md;
   logic [14:0] op_r;
   assign take = issue_valid && issue_ready;
   assign opc = issue_instr.opcode;
   assign md = issue_instr.m;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   // Operand of the instruction last taken
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
         op_r <= 15'h0000;
      else if (take)
         op_r <= issue_instr.y +
            ((issue_instr.b != 3'h0) ? index_val : 15'h0000);
   sw_rpt_a: assert property (
      take && opc == `CJX_OP_SWJ && md == 3'h0 && rpt_active
      |-> ##[1:2] rpt_end) else $error("switch jump repeat not ended");
   sw_off_a: assert property (
      take && opc == `CJX_OP_SWJ && md == 3'h1 && !jump_sw[0] && rpt_active
      |=> !rpt_end [*2]) else $error("switch jump with switch off");
   sns_rpt_a: assert property (
      take && opc == `CJX_OP_SENSE && md == 3'h1 && in_full && rpt_active
      |-> ##[1:2] rpt_end) else $error("sense repeat not ended");
   ef_code_a: assert property (
      $rose(ef_send) |-> ef_code == op_r) else $error("function code wrong");
   ef_lock_a: assert property (
      ef_send && !ef_resume |=> ef_send) else $error("lock dropped early");
   ef_drop_a: assert property (
      ef_send && ef_resume |=> !ef_send) else $error("lock kept on resume");
   hang_kept_a: assert property (
      ef_hung |=> ef_hung && !issue_ready) else $error("hang released");
   ret_p_a: assert property (
      done && res.st_en |-> res.next_p == res.st_addr + 15'h0001)
      else $error("return jump target wrong");
   halt_keep_a: assert property (
      halted && !avs_write |=> halted && $stable(u_instr))
      else $error("stop state lost");
   halt_op_a: assert property (
      $rose(halted) |-> u_instr.opcode == `CJX_OP_SWS)
      else $error("stop without switch stop");
   jmp_time_a: assert property (
      take && opc inside {`CJX_OP_SENSE, `CJX_OP_SWJ, `CJX_OP_SWS}
      |-> ##[1:TMAX] done) else $error("jump never finished");
endmodule
bind cjx_core cjx_core_sva #(.T56_CYC(T56_CYC)) i_cjx_core_sva (.*);

// ### dv/cjx_periph.sv
// Peripheral control unit model on the function code lines
`timescale 1ns/100ps
module cjx_periph (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic slow,
   input wire logic [14:0] ef_code,
   input wire logic ef_send,
   output logic ef_resume,
   output logic ef_hold
);
   logic [3:0] cnt_r;
   logic hold_r;
   logic tog_r;
   logic known;
   // Fault groups match no unit, so nobody answers
   assign known = !(ef_code[14:12] inside {3'h3, 3'h5, 3'h6, 3'h7});
   // Hold only means something with resume; otherwise it wanders
   assign ef_hold = ef_resume ? hold_r : tog_r;
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
      begin
         cnt_r <= 4'h0;
         ef_resume <= 1'b0;
         hold_r <= 1'b0;
         tog_r <= 1'b0;
      end
      else
      begin
         tog_r <= !tog_r;
         ef_resume <= 1'b0;
         cnt_r <= 4'h0;
         if (ef_send && known && !ef_resume)
         begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == (slow ? 4'h9 : 4'h1))
            begin
               ef_resume <= 1'b1;
               hold_r <= ef_code[14:12] inside {3'h1, 3'h2};
            end
         end
      end
endmodule

// ### dv/tb_cjx_core.sv
// Self-checking bench for the jump and external function block
`timescale 1ns/100ps
`include "cjx_consts.svh"
module tb_cjx_core;
   localparam int N56 = 20;
   localparam int N52 = 17;
   localparam int N41 = 14;
   localparam int N40 = 11;
   localparam int N36 = 8;
   localparam int N29 = 5;
   localparam int N20 = 2;
   localparam logic [14:0] Y = 15'h0200;
   localparam cjx_pkg::cjx_jump_t NJ = cjx_pkg::CJX_NOJ;
   localparam cjx_pkg::cjx_jump_t NM = cjx_pkg::CJX_NORM;
   localparam cjx_pkg::cjx_jump_t RT = cjx_pkg::CJX_RET;
   localparam cjx_pkg::cjx_jump_t TR = cjx_pkg::CJX_TRC;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic issue_valid = 1'b0;
   cjx_pkg::cjx_instr_t issue_instr = '0;
   logic [14:0] issue_p = 15'h0100;
   logic [14:0] index_val = 15'h0010;
   logic rpt_active = 1'b0;
   logic [2:0] jump_sw = 3'h0;
   logic [2:0] stop_sw = 3'h0;
   logic ext_sense = 1'b0;
   logic in_full = 1'b0;
   logic out_empty = 1'b0;
   logic trace_set = 1'b0;
   logic io_done = 1'b0;
   logic slow = 1'b0;
   cjx_pkg::cjx_result_t res;
   cjx_pkg::cjx_instr_t u_instr;
   logic [14:0] ef_code;
   logic issue_ready, done, rpt_end, halted, ef_send, ef_resume, ef_hold;
   logic ef_hung;
   logic [31:0] q;
   logic [2:0] mm;
   logic sel;
   int nn;
   int num_errors = 0;
   int compares = 0;
   int cyc = 0;
   cjx_core #(.T56_CYC(N56), .T52_CYC(N52), .T41_CYC(N41), .T40_CYC(N40),
      .T36_CYC(N36), .T29_CYC(N29), .T20_CYC(N20)) i_cjx_core (.*);
   cjx_periph i_cjx_periph (.*);
   always #5 sys_clk = ~sys_clk;
   task automatic stop_test;
      if (num_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         num_errors = num_errors + 1;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Done is seen one edge after the last counted cycle
   task automatic chkn(input int e, input int g);
      compares++;
      if (g != e + 1)
      begin
         num_errors++;
         $display("unexpected cycles expected %0d seen %0d", e + 1, g);
      end
   endtask
   task automatic rst;
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
   endtask
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !w;
      avs_write <= w;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge sys_clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic offer(input cjx_pkg::cjx_instr_t ins);
      issue_instr <= ins;
      issue_valid <= 1'b1;
      @(posedge sys_clk);
      while (issue_ready !== 1'b1)
         @(posedge sys_clk);
      issue_valid <= 1'b0;
   endtask
   task automatic go(input logic [5:0] op, input logic [2:0] m,
      input logic [2:0] b, input logic [14:0] y, input logic r,
      input cjx_pkg::cjx_jump_t k, input int n, input logic s);
      cjx_pkg::cjx_instr_t ins;
      logic [14:0] o;
      logic [14:0] nx;
      logic re;
      int c;
      ins = '{op, m, b, y};
      o = (b != 3'h0) ? y + index_val : y;
      nx = (k == NJ) ? issue_p + 15'h0001 : (k == NM) ? o :
         (k == RT) ? o + 15'h0001 : `CJX_MON_ENTRY;
      rpt_active <= r;
      offer(ins);
      c = 0;
      re = 1'b0;
      while (done !== 1'b1)
      begin
         @(posedge sys_clk);
         c++;
         re = re | (rpt_end === 1'b1);
      end
      if (n > 0)
         chkn(n, c);
      if (op == `CJX_OP_EXF)
         chk("ef_code", o, ef_code);
      else
      begin
         chk("next_p", nx, res.next_p);
         chk("st_en", k == RT || k == TR, res.st_en);
         if (k == RT || k == TR)
         begin
            chk("st_addr", (k == TR) ? `CJX_TRACE_SLOT : o, res.st_addr);
            chk("st_data", issue_p + 15'h0001, res.st_data);
         end
      end
      chk("rpt_end", r && k != NJ, re);
      @(posedge sys_clk);
      chk("halted", s, halted);
      if (s)
      begin
         chk("u_instr", ins, u_instr);
         chk("issue_ready", 1'b0, issue_ready);
         bus(1'b1, `CJX_REG_CTRL, 32'h2);
      end
   endtask
   initial
   begin
      rst();
      bus(1'b0, `CJX_REG_STAT, 32'h0);
      chk("status", 32'h0, q);
      bus(1'b0, 4'h2, 32'h0);
      chk("unmapped", 32'h0, q);
      ext_sense <= 1'b1;
      go(`CJX_OP_SENSE, 3'h0, 3'h0, Y, 1'b1, NM, N40, 1'b0);
      ext_sense <= 1'b0;
      go(`CJX_OP_SENSE, 3'h4, 3'h0, Y, 1'b0, NJ, N40, 1'b0);
      in_full <= 1'b1;
      go(`CJX_OP_SENSE, 3'h5, 3'h0, Y, 1'b1, RT, N56, 1'b0);
      go(`CJX_OP_SENSE, 3'h1, 3'h0, Y, 1'b1, NM, N40, 1'b0);
      in_full <= 1'b0;
      go(`CJX_OP_SENSE, 3'h1, 3'h0, Y, 1'b1, NJ, N40, 1'b0);
      out_empty <= 1'b1;
      go(`CJX_OP_SENSE, 3'h2, 3'h0, Y, 1'b0, NM, N40, 1'b0);
      out_empty <= 1'b0;
      go(`CJX_OP_SENSE, 3'h6, 3'h0, Y, 1'b0, NJ, N40, 1'b0);
      go(`CJX_OP_SENSE, 3'h3, 3'h0, Y, 1'b0, NM, N40, 1'b0);
      jump_sw <= 3'h2;
      for (int i = 0; i < 8; i++)
      begin
         mm = i;
         sel = mm[1:0] == 2'h0 || mm[1:0] == 2'h2;
         go(`CJX_OP_SWJ, mm, 3'h0, Y, 1'b0, !sel ? NJ : mm[2] ? RT : NM,
            (sel && mm[2]) ? N56 : N40, 1'b0);
      end
      go(`CJX_OP_SWJ, 3'h1, 3'h0, Y, 1'b1, NJ, N20, 1'b0);
      go(`CJX_OP_SWJ, 3'h0, 3'h0, Y, 1'b1, NM, N40, 1'b0);
      go(`CJX_OP_SWJ, 3'h4, 3'h1, Y, 1'b0, RT, N56, 1'b0);
      stop_sw <= 3'h4;
      for (int i = 0; i < 8; i++)
      begin
         mm = i;
         sel = mm[1:0] == 2'h0 || mm[1:0] == 2'h3;
         nn = mm[2] ? ((sel && mm[1:0] != 2'h0) ? N41 : N52) :
            ((sel && mm[1:0] != 2'h0) ? N29 : N36);
         go(`CJX_OP_SWS, mm, 3'h0, Y, 1'b1, mm[2] ? RT : NM, nn,
            sel);
      end
      bus(1'b1, `CJX_REG_CTRL, 32'h1);
      bus(1'b0, `CJX_REG_STAT, 32'h0);
      chk("trace", 1'b1, q[`CJX_STAT_TRACE]);
      ext_sense <= 1'b1;
      go(`CJX_OP_SENSE, 3'h0, 3'h0, Y, 1'b0, TR, N56, 1'b0);
      go(`CJX_OP_SWJ, 3'h0, 3'h0, Y, 1'b0, NM, N40, 1'b0);
      trace_set <= 1'b1;
      @(posedge sys_clk);
      trace_set <= 1'b0;
      go(`CJX_OP_SWJ, 3'h3, 3'h0, Y, 1'b0, NJ, N40, 1'b0);
      go(`CJX_OP_SWS, 3'h1, 3'h0, Y, 1'b0, TR, N36, 1'b0);
      go(`CJX_OP_EXF, 3'h0, 3'h1, 15'h0840, 1'b0, NJ, 0, 1'b0);
      slow <= 1'b1;
      go(`CJX_OP_EXF, 3'h0, 3'h0, 15'h0840, 1'b0, NJ, 0, 1'b0);
      go(`CJX_OP_EXF, 3'h0, 3'h0, 15'h1400, 1'b0, NJ, 0, 1'b0);
      go(`CJX_OP_SENSE, 3'h7, 3'h0, Y, 1'b0, NJ, N40, 1'b0);
      bus(1'b0, `CJX_REG_STAT, 32'h0);
      chk("hold", 1'b1, q[`CJX_STAT_HOLD]);
      bus(1'b0, `CJX_REG_EFC, 32'h0);
      chk("efc", 32'h1400, q);
      io_done <= 1'b1;
      @(posedge sys_clk);
      io_done <= 1'b0;
      go(`CJX_OP_SENSE, 3'h7, 3'h0, Y, 1'b0, RT, N56, 1'b0);
      go(`CJX_OP_EXF, 3'h0, 3'h0, 15'h1400, 1'b0, NJ, 0, 1'b0);
      offer('{`CJX_OP_EXF, 3'h0, 3'h0, 15'h0840});
      repeat (20) @(posedge sys_clk);
      chk("ef_hung", 1'b1, ef_hung);
      chk("issue_ready", 1'b0, issue_ready);
      rst();
      offer('{`CJX_OP_EXF, 3'h0, 3'h0, 15'h3000});
      repeat (30) @(posedge sys_clk);
      chk("ef_send", 1'b1, ef_send);
      chk("issue_ready", 1'b0, issue_ready);
      rst();
      stop_test();
   end
endmodule
